/* File: verilog/pmc_pkg.sv */
// Purpose: Constants and types shared by the power mode controller
// Assumes: 10 MHz system clock
// Notes:   Wakeup times are printed in ns and turned into cycle counts
package pmc_pkg;

  // ****************************************
  // Modes and states
  // ****************************************
  typedef enum logic [2:0] {
    PMC_ST_ACTIVE    = 3'h0,
    PMC_ST_ALT       = 3'h1,
    PMC_ST_SLEEP     = 3'h2,
    PMC_ST_HIBERNATE = 3'h3,
    PMC_ST_WAKE      = 3'h4
  } pmc_state_t;

  typedef enum logic [1:0] {
    PMC_REQ_ACTIVE    = 2'h0,
    PMC_REQ_ALT       = 2'h1,
    PMC_REQ_SLEEP     = 2'h2,
    PMC_REQ_HIBERNATE = 2'h3
  } pmc_req_t;

  // ****************************************
  // Widths and field positions
  // ****************************************
  localparam int unsigned NUM_SUBSYS            = 8;
  localparam int unsigned NUM_WAKE              = 6;
  localparam int unsigned WK_CMP                = 0;
  localparam int unsigned WK_PIN                = 1;
  localparam int unsigned WK_I2C                = 2;
  localparam int unsigned WK_RTC                = 3;
  localparam int unsigned WK_TW                 = 4;
  localparam int unsigned WK_LOW_VOLTAGE_DETECT = 5;

  localparam logic [NUM_WAKE-1:0]   SLEEP_WAKE_MASK = 6'h3F;
  localparam logic [NUM_WAKE-1:0]   HIB_WAKE_MASK   = 6'h02;
  localparam logic [NUM_SUBSYS-1:0] SLEEP_KEEP_MASK = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS     = 100;
  localparam int unsigned SLEEP_WAKE_NS     = 15000;
  localparam int unsigned HIB_WAKE_NS       = 100000;
  // Load values keep three cycles back for load, timer done and mode registers, so wake stays under the limit
  localparam int unsigned SLEEP_WAKE_CYC    = (SLEEP_WAKE_NS / CLK_PERIOD_NS) - 3;
  localparam int unsigned HIB_WAKE_CYC      = (HIB_WAKE_NS / CLK_PERIOD_NS) - 3;
  localparam int unsigned WAKE_CNT_W        = 10;
  localparam logic [WAKE_CNT_W-1:0] SLEEP_WAKE_CNT = WAKE_CNT_W'(SLEEP_WAKE_CYC);
  localparam logic [WAKE_CNT_W-1:0] HIB_WAKE_CNT   = WAKE_CNT_W'(HIB_WAKE_CYC);

endpackage

/* File: verilog/pmc_wake_timer.sv */
// Purpose: Down-counter timing the resume after a wakeup event
// Assumes: Load and count share the system clock
// Notes:   o_done pulses for one cycle when the count runs out
`timescale 1ns/1ns
module pmc_wake_timer (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_resetn,
  input  wire logic                           i_load,
  input  wire logic [pmc_pkg::WAKE_CNT_W-1:0] i_count,
  output logic                                o_busy,
  output logic                                o_done
);

  logic [pmc_pkg::WAKE_CNT_W-1:0] cnt_q;
  logic                           busy_q;
  logic                           done_q;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (i_load) begin
        cnt_q  <= i_count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == '0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 1'b1;
        end
      end
    end
  end

  assign o_busy = busy_q;
  assign o_done = done_q;

endmodule

/* File: verilog/pmc_power_mode_controller.sv */
// Purpose: Power mode controller choosing among four operating modes
// Assumes: Inputs synchronous to i_sys_clk; i_resetn is the external reset pin path
// Notes:   Mode requests are one-cycle strobes with a mode code
//
// Overview of operation
// - Four modes ranked by consumption: active, alternate active, sleep, hibernate.
// - Active entered on reset, wakeup or request; an interrupt returns to active from alternate active only.
// - In active each subsystem enable follows its bit of the active template.
// - Alternate active entered only by request, uses own template, interrupt wakes.
// - Sleep entry forces all subsystems off regardless of templates.
// - Sleep keeps slow clocks; listed events wake within 15 us.
// - Hibernate stops all clocks and peripherals, state kept.
// - Only pin interrupt leaves hibernate, within 100 us; only external reset resets.
`timescale 1ns/1ns
module pmc_power_mode_controller (
  input  wire logic                           i_sys_clk,
  input  wire logic                           i_resetn,
  input  wire logic                           i_mode_req,
  input  wire logic [1:0]                     i_mode_sel,
  input  wire logic [pmc_pkg::NUM_SUBSYS-1:0] i_active_template,
  input  wire logic [pmc_pkg::NUM_SUBSYS-1:0] i_alt_template,
  input  wire logic                           i_irq,
  input  wire logic [pmc_pkg::NUM_WAKE-1:0]   i_wake_evt,
  input  wire logic                           i_io_supply_ok,
  output logic      [pmc_pkg::NUM_SUBSYS-1:0] o_subsys_en,
  output logic      [1:0]                     o_mode,
  output logic                                o_cpu_run,
  output logic                                o_fast_clk_en,
  output logic                                o_slow_clk_en,
  output logic                                o_retain,
  output logic                                o_wake_pulse
);

  // ****************************************
  // State
  // ****************************************
  pmc_pkg::pmc_state_t                 state_q;
  pmc_pkg::pmc_state_t                 state_d;
  logic [pmc_pkg::NUM_SUBSYS-1:0]      en_q;
  logic [1:0]                          mode_q;
  logic                                fast_q;
  logic                                slow_q;
  logic                                retain_q;
  logic                                wake_pulse_q;
  logic                                low_ok;
  logic                                sleep_hit;
  logic                                hib_hit;
  logic                                tmr_load;
  logic [pmc_pkg::WAKE_CNT_W-1:0]      tmr_count;
  logic                                tmr_done;

  assign low_ok    = i_io_supply_ok;
  assign sleep_hit = |(i_wake_evt & pmc_pkg::SLEEP_WAKE_MASK);
  assign hib_hit   = |(i_wake_evt & pmc_pkg::HIB_WAKE_MASK);

  // ****************************************
  // Mode transitions
  // ****************************************
  always_comb begin
    state_d   = state_q;
    tmr_load  = 1'b0;
    tmr_count = pmc_pkg::SLEEP_WAKE_CNT;
    unique case (state_q)
      pmc_pkg::PMC_ST_ACTIVE, pmc_pkg::PMC_ST_ALT: begin
        if (i_mode_req) begin
          unique case (pmc_pkg::pmc_req_t'(i_mode_sel))
            pmc_pkg::PMC_REQ_ACTIVE:    state_d = pmc_pkg::PMC_ST_ACTIVE;
            pmc_pkg::PMC_REQ_ALT:       state_d = pmc_pkg::PMC_ST_ALT;
            pmc_pkg::PMC_REQ_SLEEP: begin
              if (low_ok) begin
                state_d = pmc_pkg::PMC_ST_SLEEP;
              end
            end
            pmc_pkg::PMC_REQ_HIBERNATE: begin
              if (low_ok) begin
                state_d = pmc_pkg::PMC_ST_HIBERNATE;
              end
            end
          endcase
        end else if (i_irq && state_q == pmc_pkg::PMC_ST_ALT) begin
          state_d = pmc_pkg::PMC_ST_ACTIVE;
        end
      end
      pmc_pkg::PMC_ST_SLEEP: begin
        if (sleep_hit) begin
          state_d   = pmc_pkg::PMC_ST_WAKE;
          tmr_load  = 1'b1;
          tmr_count = pmc_pkg::SLEEP_WAKE_CNT;
        end
      end
      pmc_pkg::PMC_ST_HIBERNATE: begin
        if (hib_hit) begin
          state_d   = pmc_pkg::PMC_ST_WAKE;
          tmr_load  = 1'b1;
          tmr_count = pmc_pkg::HIB_WAKE_CNT;
        end
      end
      pmc_pkg::PMC_ST_WAKE: begin
        if (tmr_done) begin
          state_d = pmc_pkg::PMC_ST_ACTIVE;
        end
      end
      default: state_d = pmc_pkg::PMC_ST_ACTIVE;
    endcase
  end

  // ****************************************
  // Wake timer
  // ****************************************
  pmc_wake_timer u_wake_timer (
    .i_sys_clk (i_sys_clk),
    .i_resetn  (i_resetn),
    .i_load    (tmr_load),
    .i_count   (tmr_count),
    .o_busy    (),
    .o_done    (tmr_done)
  );

  // ****************************************
  // State register
  // ****************************************

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q <= pmc_pkg::PMC_ST_ACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Subsystem gating
  // ****************************************
  for (genvar g = 0; g < pmc_pkg::NUM_SUBSYS; g++) begin : g_gate
    logic gate_q;
    always_ff @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
        gate_q <= 1'b0;
      end else begin
        unique case (state_d)
          pmc_pkg::PMC_ST_ACTIVE:    gate_q <= i_active_template[g];
          pmc_pkg::PMC_ST_ALT:       gate_q <= i_alt_template[g];
          pmc_pkg::PMC_ST_SLEEP:     gate_q <= pmc_pkg::SLEEP_KEEP_MASK[g];
          pmc_pkg::PMC_ST_HIBERNATE: gate_q <= 1'b0;
          pmc_pkg::PMC_ST_WAKE:      gate_q <= 1'b0;
          default:                   gate_q <= 1'b0;
        endcase
      end
    end
    assign en_q[g] = gate_q;
  end

  // ****************************************
  // Clocks, retention and mode code
  // ****************************************
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_q   <= 2'h0;
      fast_q   <= 1'b1;
      slow_q   <= 1'b1;
      retain_q <= 1'b0;
    end else begin
      unique case (state_d)
        pmc_pkg::PMC_ST_ACTIVE: begin
          mode_q   <= 2'h0;
          fast_q   <= 1'b1;
          slow_q   <= 1'b1;
          retain_q <= 1'b0;
        end
        pmc_pkg::PMC_ST_ALT: begin
          mode_q   <= 2'h1;
          fast_q   <= 1'b1;
          slow_q   <= 1'b1;
          retain_q <= 1'b0;
        end
        pmc_pkg::PMC_ST_SLEEP: begin
          mode_q   <= 2'h2;
          fast_q   <= 1'b0;
          slow_q   <= 1'b1;
          retain_q <= 1'b1;
        end
        pmc_pkg::PMC_ST_HIBERNATE: begin
          mode_q   <= 2'h3;
          fast_q   <= 1'b0;
          slow_q   <= 1'b0;
          retain_q <= 1'b1;
        end
        pmc_pkg::PMC_ST_WAKE: begin
          mode_q   <= 2'h0;
          fast_q   <= 1'b0;
          slow_q   <= 1'b1;
          retain_q <= 1'b0;
        end
        default: begin
          mode_q   <= 2'h0;
          fast_q   <= 1'b1;
          slow_q   <= 1'b1;
          retain_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wake_pulse_q <= 1'b0;
    end else begin
      wake_pulse_q <= (state_q == pmc_pkg::PMC_ST_WAKE) && tmr_done;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_subsys_en   = en_q;
  assign o_mode        = mode_q;
  assign o_cpu_run     = fast_q;
  assign o_fast_clk_en = fast_q;
  assign o_slow_clk_en = slow_q;
  assign o_retain      = retain_q;
  assign o_wake_pulse  = wake_pulse_q;

endmodule

/* File: tb/pmc_checker.sv */
// Purpose: Port assertions for the power mode controller
// Assumes: Bound to pmc_power_mode_controller
// Notes:   Wake bounds are strict cycle limits
`timescale 1ns/1ns
module pmc_checker (
  input wire logic                           i_sys_clk,
  input wire logic                           i_resetn,
  input wire logic                           i_mode_req,
  input wire logic [1:0]                     i_mode_sel,
  input wire logic [pmc_pkg::NUM_SUBSYS-1:0] i_active_template,
  input wire logic [pmc_pkg::NUM_SUBSYS-1:0] i_alt_template,
  input wire logic                           i_irq,
  input wire logic [pmc_pkg::NUM_WAKE-1:0]   i_wake_evt,
  input wire logic                           i_io_supply_ok,
  input wire logic [pmc_pkg::NUM_SUBSYS-1:0] o_subsys_en,
  input wire logic [1:0]                     o_mode,
  input wire logic                           o_cpu_run,
  input wire logic                           o_fast_clk_en,
  input wire logic                           o_slow_clk_en,
  input wire logic                           o_retain,
  input wire logic                           o_wake_pulse
);
  localparam int SLP_MAX = 150;
  localparam int HIB_MAX = 1000;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);
  // ****************
  // Assertions
  // ****************
  act_tmpl_a: assert property ($past(i_resetn) && o_cpu_run && o_mode == 2'h0
    && $past(o_cpu_run && o_mode == 2'h0)
    |-> o_subsys_en == $past(i_active_template)) else $error("active template not applied");
  alt_tmpl_a: assert property (o_mode == 2'h1 && $past(o_mode == 2'h1)
    |-> o_subsys_en == $past(i_alt_template)) else $error("alternate template not applied");
  alt_entry_a: assert property (o_cpu_run && i_mode_req && i_mode_sel == 2'h1
    |=> o_mode == 2'h1 && o_cpu_run) else $error("alternate entry missed");
  irq_back_a: assert property (o_mode == 2'h1 && i_irq && !i_mode_req |=> o_mode == 2'h0)
    else $error("interrupt did not return to active");
  sleep_off_a: assert property (o_mode == 2'h2 |-> o_subsys_en == 8'h00 && !o_fast_clk_en && o_retain)
    else $error("sleep left something running");
  hib_stop_a: assert property (o_mode == 2'h3 |-> !o_slow_clk_en && !o_fast_clk_en && o_retain)
    else $error("hibernate clocks running");
  supply_gate_a: assert property (o_cpu_run && i_mode_req && i_mode_sel[1] && !i_io_supply_ok
    |=> o_cpu_run) else $error("low power entered without supplies");
  hib_ignore_a: assert property (o_mode == 2'h3 && !i_wake_evt[1] |=> o_mode == 2'h3)
    else $error("hibernate left without pin event");
  sleep_wake_a: assert property (o_mode == 2'h2 && |i_wake_evt |-> ##[1:SLP_MAX] o_fast_clk_en)
    else $error("sleep wake too slow");
  hib_wake_a: assert property (o_mode == 2'h3 && i_wake_evt[1] |-> ##[1:HIB_MAX] o_fast_clk_en)
    else $error("hibernate wake too slow");
  pulse_one_a: assert property (o_wake_pulse |=> !o_wake_pulse)
    else $error("wake pulse too long");
  cover property (o_mode == 2'h2 && |i_wake_evt);
  cover property (o_mode == 2'h3 && i_wake_evt[1]);
  cover property (o_wake_pulse);
endmodule
bind pmc_power_mode_controller pmc_checker chk_u (
  .i_sys_clk         (i_sys_clk),
  .i_resetn          (i_resetn),
  .i_mode_req        (i_mode_req),
  .i_mode_sel        (i_mode_sel),
  .i_active_template (i_active_template),
  .i_alt_template    (i_alt_template),
  .i_irq             (i_irq),
  .i_wake_evt        (i_wake_evt),
  .i_io_supply_ok    (i_io_supply_ok),
  .o_subsys_en       (o_subsys_en),
  .o_mode            (o_mode),
  .o_cpu_run         (o_cpu_run),
  .o_fast_clk_en     (o_fast_clk_en),
  .o_slow_clk_en     (o_slow_clk_en),
  .o_retain          (o_retain),
  .o_wake_pulse      (o_wake_pulse)
);

/* File: tb/pmc_power_mode_controller_tb.sv */
// Purpose: Self-checking bench for the power mode controller
// Assumes: Inputs driven on falling edge
// Notes:   Wake times counted in falling edges from the edge that drives the event
`timescale 1ns/1ns
module pmc_power_mode_controller_tb;
  logic                           i_sys_clk, i_resetn, i_mode_req, i_irq, i_io_supply_ok;
  logic [1:0]                     i_mode_sel, o_mode;
  logic [pmc_pkg::NUM_SUBSYS-1:0] i_active_template, i_alt_template, o_subsys_en;
  logic [pmc_pkg::NUM_WAKE-1:0]   i_wake_evt;
  logic                           o_cpu_run, o_fast_clk_en, o_slow_clk_en, o_retain, o_wake_pulse;
  int                             n_errors, tests_run, cyc, n;
  pmc_power_mode_controller dut (
    .i_sys_clk         (i_sys_clk),
    .i_resetn          (i_resetn),
    .i_mode_req        (i_mode_req),
    .i_mode_sel        (i_mode_sel),
    .i_active_template (i_active_template),
    .i_alt_template    (i_alt_template),
    .i_irq             (i_irq),
    .i_wake_evt        (i_wake_evt),
    .i_io_supply_ok    (i_io_supply_ok),
    .o_subsys_en       (o_subsys_en),
    .o_mode            (o_mode),
    .o_cpu_run         (o_cpu_run),
    .o_fast_clk_en     (o_fast_clk_en),
    .o_slow_clk_en     (o_slow_clk_en),
    .o_retain          (o_retain),
    .o_wake_pulse      (o_wake_pulse)
  );
  initial begin
    i_sys_clk = 0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  // ****************
  // Helpers
  // ****************
  task automatic end_of_test();
    $display("checks=%0d mismatches=%0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [1:0] sel);
    @(negedge i_sys_clk) i_mode_req = 1'b1;
    i_mode_sel = sel;
    @(negedge i_sys_clk) i_mode_req = 1'b0;
  endtask
  task automatic wake(input logic [5:0] evt);
    @(negedge i_sys_clk) i_wake_evt = evt;
    n = 0;
    while (o_fast_clk_en !== 1'b1 && n < 1100) begin
      @(negedge i_sys_clk) n++;
    end
    i_wake_evt = 6'h00;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_active();
    chk(8'(o_mode), 8'h00);
    chk(o_subsys_en, 8'hA5);
    i_active_template = 8'h5A;
    @(negedge i_sys_clk);
    chk(o_subsys_en, 8'h5A);
    $display("test active done");
  endtask
  task automatic t_alt();
    req(2'h1);
    chk(8'(o_mode), 8'h01);
    chk(o_subsys_en, i_alt_template);
    i_irq = 1'b1;
    @(negedge i_sys_clk) i_irq = 1'b0;
    chk(8'(o_mode), 8'h00);
    chk(o_subsys_en, i_active_template);
    req(2'h1);
    chk(8'(o_mode), 8'h01);
    req(2'h0);
    chk(8'(o_mode), 8'h00);
    chk(8'(o_cpu_run), 8'h01);
    $display("test alt done");
  endtask
  task automatic t_refuse();
    i_io_supply_ok = 1'b0;
    req(2'h2);
    chk(8'(o_mode), 8'h00);
    req(2'h3);
    chk(8'(o_mode), 8'h00);
    chk(8'(o_cpu_run), 8'h01);
    i_io_supply_ok = 1'b1;
    $display("test refuse done");
  endtask
  task automatic t_sleep();
    for (int k = 0; k < 6; k++) begin
      req(2'h2);
      chk(8'(o_mode), 8'h02);
      chk(o_subsys_en, 8'h00);
      chk(8'(o_retain), 8'h01);
      chk(8'(o_fast_clk_en), 8'h00);
      chk(8'(o_slow_clk_en), 8'h01);
      i_irq = 1'b1;
      repeat (3) @(negedge i_sys_clk);
      i_irq = 1'b0;
      chk(8'(o_mode), 8'h02);
      wake(6'(6'h01 << k));
      chk(8'(n <= pmc_pkg::SLEEP_WAKE_NS / pmc_pkg::CLK_PERIOD_NS), 8'h01);
      chk(o_subsys_en, i_active_template);
      chk(8'(o_wake_pulse), 8'h01);
      @(negedge i_sys_clk);
      chk(8'(o_wake_pulse), 8'h00);
    end
    $display("test sleep done");
  endtask
  task automatic t_hib();
    req(2'h3);
    chk(8'(o_mode), 8'h03);
    chk(8'(o_slow_clk_en), 8'h00);
    chk(o_subsys_en, 8'h00);
    chk(8'(o_retain), 8'h01);
    i_wake_evt = 6'h3D;
    req(2'h0);
    repeat (3) @(negedge i_sys_clk);
    chk(8'(o_mode), 8'h03);
    wake(6'h02);
    chk(8'(n <= pmc_pkg::HIB_WAKE_NS / pmc_pkg::CLK_PERIOD_NS), 8'h01);
    chk(8'(o_mode), 8'h00);
    chk(8'(o_wake_pulse), 8'h01);
    req(2'h3);
    i_resetn = 1'b0;
    @(negedge i_sys_clk) i_resetn = 1'b1;
    @(negedge i_sys_clk);
    chk(8'(o_mode), 8'h00);
    chk(8'(o_cpu_run), 8'h01);
    chk(o_subsys_en, i_active_template);
    $display("test hibernate done");
  endtask
  initial begin
    {i_resetn, i_mode_req, i_irq, i_mode_sel, i_wake_evt} = '0;
    i_io_supply_ok = 1'b1;
    i_active_template = 8'hA5;
    i_alt_template = 8'h3C;
    repeat (3) @(negedge i_sys_clk);
    i_resetn = 1'b1;
    @(negedge i_sys_clk);
    t_active();
    t_alt();
    t_refuse();
    t_sleep();
    t_hib();
    end_of_test();
  end
endmodule
